// ### rtl/ivp_pkg.sv
package ivp_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int NUM_REQ = 24;
  localparam int EVT_W   = 3;
  localparam int VEC_AW  = 6;
  localparam int VEC_DEPTH = 64;

  // ------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [15:0] IDX_INT1       = 16'hfe04;
  localparam logic [15:0] IDX_INT2       = 16'hfe05;
  localparam logic [15:0] IDX_INT3       = 16'hfe06;
  localparam logic [15:0] IDX_INT4       = 16'hfe07;
  localparam logic [15:0] IDX_EVT_STATUS = 16'hfe10;
  localparam logic [15:0] IDX_EVT_MASK   = 16'hfe11;
  localparam logic [15:0] IDX_SP         = 16'hfe12;

  // ------------------------------------------------------------------
  // vector area and stack
  // ------------------------------------------------------------------
  localparam logic [15:0] VEC_BASE  = 16'hffcc;
  localparam logic [15:0] VEC_TOP   = 16'hffff;
  localparam logic [15:0] VEC_SWI   = 16'hfffc;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] SP_RESET  = 16'h00ff;
  localparam logic [15:0] RAM0_LO   = 16'h0040;
  localparam logic [15:0] RAM0_HI   = 16'h043f;
  localparam logic [15:0] RAM1_LO   = 16'h0580;
  localparam logic [15:0] RAM1_HI   = 16'h097f;
  localparam logic [2:0]  INT_STACK_BYTES  = 3'd5;
  localparam logic [2:0]  CALL_STACK_BYTES = 3'd2;
  localparam logic [7:0]  VEC_ERASED = 8'hff;

  // ------------------------------------------------------------------
  // events, sources, reset values, ahb wait
  // ------------------------------------------------------------------
  localparam int EVT_TAKEN    = 0;
  localparam int EVT_SP_RANGE = 1;
  localparam int EVT_SWI      = 2;
  localparam logic [EVT_W-1:0] EVT_RESET  = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
  localparam logic [4:0] SRC_NONE  = 5'd0;
  localparam logic [4:0] SRC_SWI   = 5'd25;
  localparam logic [4:0] SRC_RESET = 5'd26;
  localparam logic [1:0] AHB_VEC_WAIT = 2'd2;

  // high-byte vector address per request, entry 0 is request 1
  localparam logic [15:0] VEC_HI_MAP [NUM_REQ] = '{
    16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
    16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4,
    16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffda, 16'hffd8,
    16'hffd6, 16'hffd4, 16'hffd2, 16'hffd0, 16'hffce, 16'hffcc};

  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_FETCH_HI, ST_FETCH_LO, ST_DONE, ST_PULL
  } ivp_state_t;

  // ------------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------------
  function automatic logic [VEC_AW-1:0] vec_mem_index(input logic [15:0] addr);
    logic [15:0] off;
    off = 16'(addr - VEC_BASE);
    return off[VEC_AW-1:0];
  endfunction

  function automatic logic in_ram(input logic [15:0] addr);
    return (addr >= RAM0_LO && addr <= RAM0_HI) || (addr >= RAM1_LO && addr <= RAM1_HI);
  endfunction

endpackage

// ### rtl/ivp_vec_if.sv
`timescale 1ns/1ps
interface ivp_vec_if;
  import ivp_pkg::*;
  logic              wr_en;
  logic [VEC_AW-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              rd_en;
  logic [VEC_AW-1:0] rd_addr;
  logic [7:0]        rd_data;

  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// ### rtl/ivp_vector_mem.sv
`timescale 1ns/1ps
module ivp_vector_mem
  import ivp_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // access port
  ivp_vec_if.mem    port
);

  typedef struct packed {
    logic [VEC_DEPTH-1:0][7:0] mem;
    logic [7:0]                rd_data;
  } ivp_mem_state_t;

  ivp_mem_state_t st;
  ivp_mem_state_t next_st;

  // ------------------------------------------------------------------
  // storage, read data registered
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (port.wr_en)
    begin
      next_st.mem[port.wr_addr] = port.wr_data;
    end
    // read returns the old byte on a same-cycle write
    if (port.rd_en)
    begin
      next_st.rd_data = st.mem[port.rd_addr];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // erased cells read as all ones
      st <= {(VEC_DEPTH + 1){VEC_ERASED}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign port.rd_data = st.rd_data;

endmodule // ivp_vector_mem

// ### rtl/ivp_top.sv
`timescale 1ns/1ps
module ivp_top
  import ivp_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // peripheral requests, bit i is request i+1
  input  wire logic [NUM_REQ-1:0] request_flags,
  // cpu core
  input  wire logic               cpu_int_mask,
  input  wire logic               cpu_entry_ok,
  input  wire logic               cpu_swi,
  input  wire logic               cpu_call,
  input  wire logic               cpu_rti,
  input  wire logic               cpu_rts,
  input  wire logic [15:0]        cpu_pc,
  input  wire logic [15:0]        cpu_ret_addr,
  input  wire logic [7:0]         cpu_x,
  input  wire logic [7:0]         cpu_a,
  input  wire logic [7:0]         cpu_ccr,
  // vector fetch
  output logic                    vec_fetch_valid,
  output logic [15:0]             vec_fetch_addr,
  output logic                    vec_done,
  output logic [15:0]             service_addr,
  output logic [4:0]              vec_source,
  // stack
  output logic                    stack_wr_en,
  output logic                    stack_rd_en,
  output logic [15:0]             stack_addr,
  output logic [7:0]              stack_wdata,
  output logic [15:0]             stack_ptr,
  output logic                    busy,
  // interrupt
  output logic                    irq
);

  typedef struct packed {
    ivp_state_t       state;
    logic [4:0]       src;
    logic             reset_pend;
    logic [2:0]       cnt;
    logic [2:0]       len;
    logic             is_call;
    logic [15:0]      sp;
    logic [15:0]      stack_addr;
    logic [7:0]       wdata;
    logic [15:0]      snap_pc;
    logic [7:0]       snap_x;
    logic [7:0]       snap_a;
    logic [7:0]       snap_ccr;
    logic [15:0]      vec_addr;
    logic [7:0]       vec_hi;
    logic [15:0]      service_addr;
    logic             vec_done;
    logic [NUM_REQ-1:0] pend;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic             dp_valid;
    logic             dp_write;
    logic [15:0]      dp_idx;
    logic             dp_vec;
    logic [1:0]       dp_wait;
    logic [31:0]      hrdata;
  } ivp_state_s_t;

  ivp_state_s_t st;
  ivp_state_s_t next_st;
  ivp_vec_if    vport ();

  ivp_vector_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .port    (vport.mem)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [4:0] prio_pick(input logic [NUM_REQ-1:0] p);
    logic [4:0] pick;
    pick = SRC_NONE;
    for (int i = NUM_REQ - 1; i >= 0; i--)
    begin
      if (p[i])
      begin
        pick = 5'(i + 1);
      end
    end
    return pick;
  endfunction

  // one formula covers every numbered vector pair
  function automatic logic [15:0] vec_hi_addr(input logic [4:0] src);
    if (src == SRC_RESET)
    begin
      return VEC_RESET;
    end
    else if (src == SRC_SWI)
    begin
      return VEC_SWI;
    end
    return 16'(VEC_SWI - {10'h000, src, 1'b0});
  endfunction

  // order: pc low, pc high, x, a, ccr; the high index is left out
  function automatic logic [7:0] push_byte(input logic [2:0] idx, input logic [15:0] pc,
                                           input logic [7:0] x, input logic [7:0] a,
                                           input logic [7:0] ccr);
    case (idx)
      3'd0:    return pc[7:0];
      3'd1:    return pc[15:8];
      3'd2:    return x;
      3'd3:    return a;
      default: return ccr;
    endcase
  endfunction

  logic        ap;
  logic [15:0] ap_idx;
  logic        ap_ok;
  logic        fsm_port;
  logic        ap_vec;

  assign ap       = hsel && htrans[1] && hready;
  assign ap_idx   = haddr[17:2];
  assign ap_ok    = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
  assign ap_vec   = ap_ok && (ap_idx >= VEC_BASE) && (ap_idx <= VEC_TOP);
  assign fsm_port = (st.state == ST_FETCH_HI) || (st.state == ST_FETCH_LO);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [4:0]       win;
    logic [EVT_W-1:0] set;
    logic [EVT_W-1:0] clr;
    win           = prio_pick(st.pend & {NUM_REQ{!cpu_int_mask}});
    set           = '0;
    clr           = '0;
    next_st       = st;
    next_st.pend  = request_flags;
    next_st.vec_done = 1'b0;
    vport.rd_en   = 1'b0;
    vport.rd_addr = vec_mem_index(st.vec_addr);
    vport.wr_en   = 1'b0;
    vport.wr_addr = vec_mem_index(st.dp_idx);
    vport.wr_data = hwdata[7:0];

    case (st.state)
      ST_IDLE:
      begin
        if (st.reset_pend)
        begin
          next_st.reset_pend = 1'b0;
          next_st.src        = SRC_RESET;
          next_st.vec_addr   = vec_hi_addr(SRC_RESET);
          next_st.state      = ST_FETCH_HI;
        end
        else if (cpu_entry_ok && (cpu_swi || win != SRC_NONE))
        begin
          next_st.src      = cpu_swi ? SRC_SWI : win;
          next_st.vec_addr = vec_hi_addr(cpu_swi ? SRC_SWI : win);
          next_st.is_call  = 1'b0;
          next_st.len      = INT_STACK_BYTES;
          next_st.snap_pc  = cpu_pc;
          next_st.snap_x   = cpu_x;
          next_st.snap_a   = cpu_a;
          next_st.snap_ccr = cpu_ccr;
          next_st.wdata    = push_byte(3'd0, cpu_pc, cpu_x, cpu_a, cpu_ccr);
          next_st.cnt        = 3'd0;
          next_st.stack_addr = st.sp;
          next_st.state      = ST_PUSH;
        end
        else if (cpu_call)
        begin
          next_st.is_call    = 1'b1;
          next_st.len        = CALL_STACK_BYTES;
          next_st.snap_pc    = cpu_ret_addr;
          next_st.wdata      = cpu_ret_addr[7:0];
          next_st.cnt        = 3'd0;
          next_st.stack_addr = st.sp;
          next_st.state      = ST_PUSH;
        end
        else if (cpu_rti || cpu_rts)
        begin
          next_st.len        = cpu_rti ? INT_STACK_BYTES : CALL_STACK_BYTES;
          next_st.cnt        = 3'd0;
          next_st.stack_addr = 16'(st.sp + 16'h0001);
          next_st.state      = ST_PULL;
        end
      end
      ST_PUSH:
      begin
        next_st.sp         = 16'(st.sp - 16'h0001);
        next_st.stack_addr = 16'(st.sp - 16'h0001);
        next_st.cnt        = 3'(st.cnt + 3'd1);
        next_st.wdata      = push_byte(3'(st.cnt + 3'd1), st.snap_pc, st.snap_x,
                                       st.snap_a, st.snap_ccr);
        if (st.cnt == 3'(st.len - 3'd1))
        begin
          next_st.state = st.is_call ? ST_IDLE : ST_FETCH_HI;
        end
      end
      ST_PULL:
      begin
        next_st.sp         = 16'(st.sp + 16'h0001);
        next_st.stack_addr = 16'(st.sp + 16'h0002);
        next_st.cnt        = 3'(st.cnt + 3'd1);
        if (st.cnt == 3'(st.len - 3'd1))
        begin
          next_st.state = ST_IDLE;
        end
      end
      ST_FETCH_HI:
      begin
        vport.rd_en      = 1'b1;
        next_st.vec_addr = 16'(st.vec_addr + 16'h0001);
        next_st.state    = ST_FETCH_LO;
      end
      ST_FETCH_LO:
      begin
        vport.rd_en    = 1'b1;
        next_st.vec_hi = vport.rd_data;
        next_st.state  = ST_DONE;
      end
      ST_DONE:
      begin
        next_st.service_addr = {st.vec_hi, vport.rd_data};
        next_st.vec_done     = 1'b1;
        set[EVT_TAKEN]       = 1'b1;
        set[EVT_SWI]         = (st.src == SRC_SWI);
        next_st.state        = ST_IDLE;
      end
      default:
      begin
        next_st.state = ST_IDLE;
      end
    endcase

    // stack outside ram is flagged, not blocked
    if ((st.state == ST_PUSH || st.state == ST_PULL) && !in_ram(st.stack_addr))
    begin
      set[EVT_SP_RANGE] = 1'b1;
    end

    // ahb data phase
    if (st.dp_valid && st.dp_write)
    begin
      if (st.dp_idx == IDX_EVT_MASK)
      begin
        next_st.mask = hwdata[EVT_W-1:0];
      end
      else if (st.dp_idx == IDX_SP && next_st.state == ST_IDLE && st.state == ST_IDLE)
      begin
        next_st.sp = hwdata[15:0];
      end
      else if (st.dp_vec)
      begin
        vport.wr_en = 1'b1;
      end
    end
    if (st.dp_valid && !st.dp_write && st.dp_vec)
    begin
      if (st.dp_wait == 2'd0 && !fsm_port)
      begin
        vport.rd_en   = 1'b1;
        vport.rd_addr = vec_mem_index(st.dp_idx);
        next_st.dp_wait = 2'd1;
      end
      else if (st.dp_wait == 2'd1)
      begin
        next_st.hrdata  = {24'h000000, vport.rd_data};
        next_st.dp_wait = AHB_VEC_WAIT;
      end
    end

    // ahb address phase
    if (hreadyout)
    begin
      next_st.dp_valid = ap;
      next_st.dp_write = hwrite;
      next_st.dp_idx   = ap_idx;
      next_st.dp_vec   = ap && ap_vec;
      next_st.dp_wait  = 2'd0;
      next_st.hrdata   = 32'h00000000;
      if (ap && !hwrite && ap_ok)
      begin
        if (ap_idx == IDX_INT1)
        begin
          next_st.hrdata = {24'h000000, st.pend[5:0], 2'b00};
        end
        else if (ap_idx == IDX_INT2)
        begin
          next_st.hrdata = {24'h000000, st.pend[13:6]};
        end
        else if (ap_idx == IDX_INT3)
        begin
          next_st.hrdata = {24'h000000, st.pend[21:14]};
        end
        else if (ap_idx == IDX_INT4)
        begin
          next_st.hrdata = {30'h00000000, st.pend[23:22]};
        end
        else if (ap_idx == IDX_EVT_STATUS)
        begin
          next_st.hrdata = {29'h00000000, st.status};
          clr            = st.status;
        end
        else if (ap_idx == IDX_EVT_MASK)
        begin
          next_st.hrdata = {29'h00000000, st.mask};
        end
        else if (ap_idx == IDX_SP)
        begin
          next_st.hrdata = {16'h0000, st.sp};
        end
      end
    end

    // a new event beats the read that clears it
    next_st.status = (st.status & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st            <= '0;
      st.state      <= ST_IDLE;
      st.reset_pend <= 1'b1;
      st.sp         <= SP_RESET;
      st.status     <= EVT_RESET;
      st.mask       <= MASK_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign hreadyout       = !(st.dp_valid && !st.dp_write && st.dp_vec &&
                             st.dp_wait != AHB_VEC_WAIT);
  assign hrdata          = st.hrdata;
  assign hresp           = 1'b0;
  assign vec_fetch_valid = fsm_port;
  assign vec_fetch_addr  = st.vec_addr;
  assign vec_done        = st.vec_done;
  assign service_addr    = st.service_addr;
  assign vec_source      = st.src;
  assign stack_wr_en     = (st.state == ST_PUSH);
  assign stack_rd_en     = (st.state == ST_PULL);
  assign stack_addr      = st.stack_addr;
  assign stack_wdata     = st.wdata;
  assign stack_ptr       = st.sp;
  assign busy            = (st.state != ST_IDLE) || st.reset_pend;
  assign irq             = |(st.status & st.mask);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_prio_order: assert property (
    (st.state == ST_PUSH && st.cnt == 3'd0 && !st.is_call && st.src != SRC_SWI) |->
      (!$past(cpu_int_mask) && (($past(st.pend) & 24'((24'h000001 << (st.src - 5'd1))
        - 24'h000001)) == 24'h000000)))
    else $error("lower-ranked request taken over a higher one");
  a_vec_map: assert property (
    (st.state == ST_FETCH_HI && st.src >= 5'd1 && st.src <= 5'd24) |->
      st.vec_addr == VEC_HI_MAP[st.src - 5'd1])
    else $error("request fetched from wrong vector address");
  a_vec_range: assert property (
    vec_fetch_valid |-> (vec_fetch_addr >= VEC_BASE))
    else $error("vector fetch outside vector area");
  a_stack_five: assert property (
    (st.state == ST_FETCH_HI && $past(st.state) == ST_PUSH) |->
      st.sp == 16'($past(st.sp, 5) - 16'h0005))
    else $error("interrupt entry did not stack five bytes");
  a_h_excluded: assert property (
    (stack_wr_en && !st.is_call && st.cnt == 3'd4) |->
      (stack_wdata == st.snap_ccr) ##1 !stack_wr_en)
    else $error("stacking went beyond condition codes");
  a_sp_dec: assert property (
    stack_wr_en |=> stack_ptr == 16'($past(stack_ptr) - 16'h0001))
    else $error("push did not decrement stack pointer");
  a_sp_inc: assert property (
    stack_rd_en |=> stack_ptr == 16'($past(stack_ptr) + 16'h0001))
    else $error("pull did not increment stack pointer");
  a_call_two: assert property (
    (st.state == ST_IDLE && cpu_call && !st.reset_pend && !(cpu_entry_ok && (cpu_swi ||
      prio_pick(st.pend & {NUM_REQ{!cpu_int_mask}}) != SRC_NONE))) |=>
      stack_wr_en [*2] ##1 !stack_wr_en)
    else $error("call did not push exactly two bytes");
  a_sp_reset: assert property (
    (st.state == ST_FETCH_HI && st.src == SRC_RESET) |-> st.sp == SP_RESET)
    else $error("stack pointer not at reset value");
  a_pend_int4: assert property (
    (st.dp_valid && !st.dp_write && st.dp_idx == IDX_INT4) |->
      st.hrdata[31:2] == 30'h00000000)
    else $error("unused pending bits read nonzero");
  a_swi_bypass: assert property (
    (st.state == ST_IDLE && !st.reset_pend && cpu_entry_ok && cpu_swi) |=>
      (st.state == ST_PUSH && st.src == SRC_SWI))
    else $error("software interrupt not taken");
  a_vec_pair: assert property (
    (st.state == ST_FETCH_HI) |=> (st.state == ST_FETCH_LO &&
      vec_fetch_addr == 16'($past(vec_fetch_addr) + 16'h0001)) ##2 vec_done)
    else $error("vector bytes not fetched high then low");

  c_swi_entry: cover property (st.state == ST_DONE && st.src == SRC_SWI);
  c_req_entry: cover property (st.state == ST_DONE && st.src == 5'd24);
  c_call_push: cover property (stack_wr_en && st.is_call);
  c_pull:      cover property (stack_rd_en ##1 stack_rd_en);
  c_vec_read:  cover property (st.dp_valid && st.dp_vec && !st.dp_write && hreadyout);

endmodule // ivp_top

// ### verification/ivp_cpu_model.sv
`timescale 1ns/1ps
module ivp_cpu_model
#(
  parameter logic [15:0] PC  = 16'hc35a,
  parameter logic [7:0]  X   = 8'h96,
  parameter logic [7:0]  A   = 8'h5c,
  parameter logic [7:0]  CCR = 8'he1
)
(
  // clock
  input  wire logic        hclk,
  // bench control
  input  wire logic        swi_go,
  // core side
  input  wire logic        busy,
  output logic             cpu_swi = 1'b0,
  output logic [15:0]      cpu_pc,
  output logic [7:0]       cpu_x,
  output logic [7:0]       cpu_a,
  output logic [7:0]       cpu_ccr
);
  // register file steady between entries; no high index offered
  assign cpu_pc  = PC;
  assign cpu_x   = X;
  assign cpu_a   = A;
  assign cpu_ccr = CCR;
  // request held until busy answers, else it could be lost
  always @(posedge hclk) cpu_swi <= cpu_swi ? !busy : swi_go;
endmodule // ivp_cpu_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import ivp_pkg::*;
;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam logic [15:0] PC = 16'hc35a;
  localparam logic [7:0]  RX = 8'h96, RA = 8'h5c, RC = 8'he1;
  logic               hclk, hresetn, hsel, hwrite, hreadyout, swi_go, rd_pend;
  logic               cpu_int_mask, cpu_entry_ok, cpu_call, cpu_rti, cpu_rts, cpu_swi;
  logic               vec_done, stack_wr_en, stack_rd_en, hresp, busy, irq;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [4:0]         vec_source;
  logic [7:0]         cpu_x, cpu_a, cpu_ccr, stack_wdata;
  logic [15:0]        cpu_ret_addr, cpu_pc, service_addr, stack_addr, stack_ptr, sp;
  logic [31:0]        haddr, hwdata, hrdata, r;
  logic [NUM_REQ-1:0] request_flags;
  logic [7:0]         vm [16'hffcc:16'hffff];
  logic [31:0]        rq[$], vq[$], sq[$], pq[$];
  int                 fail_count, cmp_count;

  ivp_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .request_flags, .cpu_int_mask,
    .cpu_entry_ok, .cpu_swi, .cpu_call, .cpu_rti, .cpu_rts, .cpu_pc, .cpu_ret_addr, .cpu_x,
    .cpu_a, .cpu_ccr, .vec_fetch_valid(), .vec_fetch_addr(), .vec_done, .service_addr,
    .vec_source, .stack_wr_en, .stack_rd_en, .stack_addr, .stack_wdata, .stack_ptr,
    .busy, .irq);
  ivp_cpu_model #(.PC(PC), .X(RX), .A(RA), .CCR(RC)) cpu_u (.hclk, .swi_go, .busy,
    .cpu_swi, .cpu_pc, .cpu_x, .cpu_a, .cpu_ccr);

  always #4 hclk = ~hclk;

  // ------------------------------------------------------------------
  // checking
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude(input int extra);
    fail_count += extra;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // an unexpected result counts as a mismatch by itself
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    if (q.size() == 0) fail_count++;
    return q.size() ? q.pop_front() : 'x;
  endfunction

  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout)
    begin
      chk("hrdata", pop(rq), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (stack_rd_en) chk("pull", pop(pq), {16'h0, stack_addr});
    if (vec_done) chk("vector", pop(vq), {11'h0, vec_source, service_addr});
    if (stack_wr_en) chk("push", pop(sq), {8'h0, stack_addr, stack_wdata});
    if (hreadyout) rd_pend <= hsel && htrans[1] && !hwrite;
  end

  // ------------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {14'h0, idx, 2'b00};
    do @(posedge hclk); while (!hreadyout && ++n < 64);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (!hreadyout && ++n < 64);
    if (n >= 64) conclude(1);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic expect_entry(input logic [4:0] src, input logic [15:0] va);
    logic [7:0] b [5];
    b = '{PC[7:0], PC[15:8], RX, RA, RC};
    vq.push_back({11'h0, src, vm[va], vm[va + 16'h1]});
    for (int i = 0; i < 5; i++) sq.push_back({8'h0, sp - 16'(i), b[i]});
    sp = sp - 16'h5;
  endtask

  // requests drop once taken, so a level cannot be served twice
  task automatic service();
    int n;
    n = 0;
    do @(posedge hclk); while (!busy && ++n < 64);
    request_flags <= '0;
    swi_go        <= 1'b0;
    do @(posedge hclk); while (busy && ++n < 64);
    if (n >= 64) conclude(1);
  endtask

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    {hclk, hresetn, hsel, hwrite, swi_go, rd_pend} = '0;
    {cpu_int_mask, cpu_entry_ok, cpu_call, cpu_rti, cpu_rts} = '0;
    {htrans, haddr, hwdata, request_flags, cpu_ret_addr} = '0;
    hsize = 3'b010;
    void'($urandom(32'h09e63e6c));
    sp = SP_RESET;
    foreach (vm[a]) vm[a] = VEC_ERASED;
    vq.push_back({11'h0, SRC_RESET, vm[VEC_RESET], vm[VEC_TOP]});
    repeat (8) @(posedge hclk);
    hresetn      <= 1'b1;
    cpu_entry_ok <= 1'b1;
    service();
    for (int i = 4; i < 8; i++) rd(16'hfe00 + 16'(i), 32'h0);
    rd(IDX_SP, {16'h0, SP_RESET});
    bus(1'b1, IDX_INT1, 32'hff);
    rd(IDX_INT1, 32'h0);
    rd(16'hfe20, 32'h0);
    for (int a = 16'hffcc; a <= 16'hffff; a++)
    begin
      vm[a] = 8'($urandom());
      bus(1'b1, 16'(a), {24'h0, vm[a]});
    end
    rd(VEC_BASE, {24'h0, vm[VEC_BASE]});
    bus(1'b1, IDX_EVT_MASK, 32'h5);
    rd(IDX_EVT_MASK, 32'h5);
    // only lower-priority requests join the winner
    for (int n = 1; n <= NUM_REQ; n++)
    begin
      expect_entry(5'(n), VEC_HI_MAP[n - 1]);
      request_flags <= NUM_REQ'(($urandom() << n) | (1 << (n - 1)));
      service();
    end
    chk("stack_ptr", {16'h0, sp}, {16'h0, stack_ptr});
    chk("irq", 32'h1, {31'h0, irq});
    rd(IDX_EVT_STATUS, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    r = $urandom() | 32'h1;
    cpu_int_mask  <= 1'b1;
    request_flags <= r[23:0];
    repeat (3) @(posedge hclk);
    rd(IDX_INT1, {24'h0, r[5:0], 2'b00});
    rd(IDX_INT2, {24'h0, r[13:6]});
    rd(IDX_INT3, {24'h0, r[21:14]});
    rd(IDX_INT4, {30'h0, r[23:22]});
    expect_entry(SRC_SWI, VEC_SWI);
    swi_go <= 1'b1;
    service();
    rd(IDX_EVT_STATUS, 32'h5);
    r = $urandom();
    cpu_int_mask <= 1'b0;
    cpu_ret_addr <= r[15:0];
    cpu_call     <= 1'b1;
    sq.push_back({8'h0, sp, r[7:0]});
    sq.push_back({8'h0, sp - 16'h1, r[15:8]});
    sp = sp - 16'h2;
    @(posedge hclk);
    cpu_call <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("stack_ptr", {16'h0, sp}, {16'h0, stack_ptr});
    for (int k = 0; k < 2; k++)
    begin
      for (int j = 1; j <= ((k == 0) ? 2 : 5); j++) pq.push_back({16'h0, sp + 16'(j)});
      cpu_rts <= (k == 0);
      cpu_rti <= (k == 1);
      @(posedge hclk);
      {cpu_rts, cpu_rti} <= 2'b00;
      repeat (6) @(posedge hclk);
      sp = sp + ((k == 0) ? 16'h2 : 16'h5);
      chk("stack_ptr", {16'h0, sp}, {16'h0, stack_ptr});
    end
    // a stack moved out of ram is still used, but flagged
    r = $urandom();
    sp = {4'h8, r[11:0]};
    bus(1'b1, IDX_SP, {16'h0, sp});
    cpu_ret_addr <= r[31:16];
    cpu_call     <= 1'b1;
    sq.push_back({8'h0, sp, r[23:16]});
    sq.push_back({8'h0, sp - 16'h1, r[31:24]});
    sp = sp - 16'h2;
    @(posedge hclk);
    cpu_call <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(IDX_EVT_STATUS, 32'h2);
    rd(IDX_SP, {16'h0, sp});
    repeat (4) @(posedge hclk);
    chk("leftover", 32'h0, 32'(rq.size() + vq.size() + sq.size() + pq.size()));
    conclude(0);
  end
endmodule // testbench
